// ---- inc/scs_map.svh ----
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 8-bit register map reached through the device's serial register port
// Notes: definitions only
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// register offsets
`define SCS_ADDR_TEMP_CFG 8'ha4
`define SCS_ADDR_ERR_IND 8'hb0
`define SCS_ADDR_REV 8'hff

// reset values and masks
`define SCS_CFG_RESET 8'h03
`define SCS_CFG_WMASK 8'h3f
`define SCS_ERR_RESET 1'b0
`define SCS_READ_ZERO 8'h00

// field positions
`define SCS_ERR_BIT 0
`define SCS_RATE_LSB 4

// timing: clock rate and measurement periods in milliseconds
`define SCS_CLK_KHZ 10000
`define SCS_RATE0_MS 100
`define SCS_RATE1_MS 1000
`define SCS_RATE2_MS 10000

`endif

// ---- inc/scs_pkg.sv ----
// Purpose: shared types of the sensor configuration and status slice
// Assumes: nothing beyond SystemVerilog packed types
// Notes: offsets and counts live in scs_map.svh
package scs_pkg;

  // register request from the serial register controller
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scs_req_t;

  // layout of the temperature sensor configuration register
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] sample_rate_select;
    logic enable_right;
    logic enable_left;
    logic right_sensor_powerdown;
    logic left_sensor_powerdown;
  } scs_cfg_t;

  // register access sequencing
  typedef enum logic {
    SCS_ACC_IDLE,
    SCS_ACC_RESP
  } scs_acc_state_t;

endpackage

// ---- rtl/scs_strap.sv ----
// Purpose: catch the single-ended video strap once after reset release
// Assumes: strap pins are stable levels synchronous to clk_sys_in
// Notes: value holds until the next reset
`timescale 1ns/10ps
module scs_strap (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic video_neg_in,
  input wire logic video_common_mode_in,
  output logic single_ended_out
);

  logic armed_q;
  logic armed_d;
  logic se_q;
  logic se_d;

  // sample once on the first edge after release, never under reset
  always_comb begin
    armed_d = 1'b1;
    se_d = se_q;
    if (!armed_q) begin
      se_d = !video_neg_in && !video_common_mode_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      armed_q <= 1'b0;
      se_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
      se_q <= se_d;
    end
  end

  assign single_ended_out = se_q;

  property p_strap_capture;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(armed_q) |-> se_q == (!$past(video_neg_in) && !$past(video_common_mode_in));
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("strap not captured at release");

  property p_strap_hold;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      armed_q && $past(armed_q) |-> $stable(se_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");

endmodule // scs_strap

// ---- rtl/scs_regs.sv ----
// Purpose: temperature sensor configuration, bus-service error flag and revision registers
// Assumes: one request per two cycles from the serial register controller
// Notes: sensor control and measurement tick derived from the configuration register
`timescale 1ns/10ps
`include "scs_map.svh"
module scs_regs #(
  parameter int unsigned RATE0_CYC = `SCS_RATE0_MS * `SCS_CLK_KHZ,
  parameter int unsigned RATE1_CYC = `SCS_RATE1_MS * `SCS_CLK_KHZ,
  parameter int unsigned RATE2_CYC = `SCS_RATE2_MS * `SCS_CLK_KHZ,
  parameter int unsigned CNT_W = 27,
  parameter logic [7:0] REV_CODE = 8'h5a // arbitrary revision value
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic req_valid_in,
  input wire scs_pkg::scs_req_t req_in,
  input wire logic svc_fail_in,
  input wire logic video_neg_in,
  input wire logic video_common_mode_in,
  output logic ack_out,
  output logic [7:0] rdata_out,
  output logic sensor_on_left_out,
  output logic sensor_on_right_out,
  output logic [1:0] sample_rate_select_out,
  output logic meas_tick_out,
  output logic single_ended_out
);

  // refuse periods that do not fit the counter or are shorter than two cycles, before any logic is built
  if (CNT_W < 2 || CNT_W > 31 || RATE0_CYC < 2 || RATE1_CYC < 2 || RATE2_CYC < 2 ||
      RATE0_CYC > (32'd1 << CNT_W) || RATE1_CYC > (32'd1 << CNT_W) ||
      RATE2_CYC > (32'd1 << CNT_W)) begin : g_bad_periods
    $error("scs_regs: measurement periods do not fit CNT_W");
  end

  scs_pkg::scs_acc_state_t st_q;
  scs_pkg::scs_acc_state_t st_d;
  scs_pkg::scs_cfg_t cfg_q;
  scs_pkg::scs_cfg_t cfg_d;
  logic err_q;
  logic err_d;
  logic ack_q;
  logic ack_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic accept;
  logic refused;
  logic fail_evt;

  assign accept = req_valid_in && (st_q == scs_pkg::SCS_ACC_IDLE);
  // a request arriving while the previous answer is out cannot be serviced
  assign refused = req_valid_in && (st_q != scs_pkg::SCS_ACC_IDLE);
  assign fail_evt = svc_fail_in || refused;

  // register access: decode, read mux, write and read-clear side effects
  always_comb begin
    st_d = st_q;
    cfg_d = cfg_q;
    err_d = err_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    case (st_q)
      scs_pkg::SCS_ACC_IDLE: begin
        if (req_valid_in) begin
          st_d = scs_pkg::SCS_ACC_RESP;
          ack_d = 1'b1;
          if (req_in.we) begin
            // failed write is dropped, revision and flag are not writable
            if (!svc_fail_in && req_in.addr == `SCS_ADDR_TEMP_CFG) begin
              cfg_d = scs_pkg::scs_cfg_t'(req_in.wdata & `SCS_CFG_WMASK);
            end
          end else begin
            case (req_in.addr)
              `SCS_ADDR_TEMP_CFG: rdata_d = cfg_q;
              `SCS_ADDR_ERR_IND: begin
                rdata_d = `SCS_READ_ZERO;
                rdata_d[`SCS_ERR_BIT] = err_q;
                err_d = 1'b0;
              end
              `SCS_ADDR_REV: rdata_d = REV_CODE;
              default: rdata_d = `SCS_READ_ZERO;
            endcase
          end
        end
      end
      scs_pkg::SCS_ACC_RESP: st_d = scs_pkg::SCS_ACC_IDLE;
      default: st_d = scs_pkg::SCS_ACC_IDLE;
    endcase
    // set wins over the read clear in the same cycle
    if (fail_evt) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= scs_pkg::SCS_ACC_IDLE;
      cfg_q <= scs_pkg::scs_cfg_t'(`SCS_CFG_RESET);
      err_q <= `SCS_ERR_RESET;
      ack_q <= 1'b0;
      rdata_q <= `SCS_READ_ZERO;
    end else begin
      st_q <= st_d;
      cfg_q <= cfg_d;
      err_q <= err_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  logic sens_l_q;
  logic sens_l_d;
  logic sens_r_q;
  logic sens_r_d;
  logic [1:0] rate_q;
  logic [1:0] rate_d;
  logic tick_q;
  logic tick_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] last_cnt;

  // sensor power state and measurement timer; a rate change restarts the period
  always_comb begin
    sens_l_d = cfg_q.enable_left && !cfg_q.left_sensor_powerdown;
    sens_r_d = cfg_q.enable_right && !cfg_q.right_sensor_powerdown;
    rate_d = cfg_q.sample_rate_select;
    case (cfg_q.sample_rate_select)
      2'h0: last_cnt = CNT_W'(RATE0_CYC - 1);
      2'h1: last_cnt = CNT_W'(RATE1_CYC - 1);
      default: last_cnt = CNT_W'(RATE2_CYC - 1);
    endcase
    tick_d = 1'b0;
    cnt_d = cnt_q + CNT_W'(1);
    if (!(sens_l_q || sens_r_q) || rate_q != cfg_q.sample_rate_select) begin
      cnt_d = '0;
    end else if (cnt_q >= last_cnt) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sens_l_q <= 1'b0;
      sens_r_q <= 1'b0;
      rate_q <= 2'h0;
      tick_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      sens_l_q <= sens_l_d;
      sens_r_q <= sens_r_d;
      rate_q <= rate_d;
      tick_q <= tick_d;
      cnt_q <= cnt_d;
    end
  end

  // strap capture for single-ended video
  scs_strap u_strap (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .video_neg_in(video_neg_in),
    .video_common_mode_in(video_common_mode_in),
    .single_ended_out(single_ended_out)
  );

  assign ack_out = ack_q;
  assign rdata_out = rdata_q;
  assign sensor_on_left_out = sens_l_q;
  assign sensor_on_right_out = sens_r_q;
  assign sample_rate_select_out = rate_q;
  assign meas_tick_out = tick_q;

  // checks
  property p_sensor_pair;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      1'b1 |=> (sensor_on_left_out == ($past(cfg_q.enable_left) && !$past(cfg_q.left_sensor_powerdown))) &&
               (sensor_on_right_out == ($past(cfg_q.enable_right) && !$past(cfg_q.right_sensor_powerdown)));
  endproperty
  a_sensor_pair: assert property (p_sensor_pair) else $error("sensor state does not follow config");

  property p_cfg_reset;
    @(posedge clk_sys_in) $rose(resetn_in) |-> cfg_q == 8'h03 && !err_q;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("wrong values after reset");

  property p_tick_needs_sensor;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      meas_tick_out |-> ($past(sens_l_q) || $past(sens_r_q)) && $past(cnt_q) == $past(last_cnt);
  endproperty
  a_tick_needs_sensor: assert property (p_tick_needs_sensor) else $error("tick off period or sensors off");

  property p_err_set;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      fail_evt |=> err_q;
  endproperty
  a_err_set: assert property (p_err_set) else $error("service failure not flagged");

  property p_fail_write_dropped;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      accept && req_in.we && svc_fail_in |=> $stable(cfg_q);
  endproperty
  a_fail_write_dropped: assert property (p_fail_write_dropped) else $error("failed write changed config");

  property p_err_read_clear;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      accept && !req_in.we && req_in.addr == 8'hb0 && !fail_evt ##1 !fail_evt |->
        !err_q && rdata_out[0] == $past(err_q) && ack_out;
  endproperty
  a_err_read_clear: assert property (p_err_read_clear) else $error("error flag not cleared by read");

  property p_rev_read;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      accept && !req_in.we && req_in.addr == 8'hff |=> rdata_out == REV_CODE ##1 !ack_out;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision read wrong");

  property p_write_cfg;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      accept && req_in.we && !svc_fail_in && req_in.addr == 8'ha4 |=> cfg_q == ($past(req_in.wdata) & 8'h3f);
  endproperty
  a_write_cfg: assert property (p_write_cfg) else $error("config write not stored");

  c_write_cfg: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
    accept && req_in.we && req_in.addr == 8'ha4);
  c_err_read_set: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
    accept && !req_in.we && req_in.addr == 8'hb0 && err_q);
  c_meas_tick: cover property (@(posedge clk_sys_in) disable iff (!resetn_in) meas_tick_out);
  c_refused: cover property (@(posedge clk_sys_in) disable iff (!resetn_in) refused);

endmodule // scs_regs

// ---- verification/scs_host.sv ----
// Purpose: register port master standing in for the serial host controller
// Assumes: one request per two cycles, answer registered on the taking edge itself
// Notes: request lines are scrambled between requests
`timescale 1ns/10ps
module scs_host (
  input wire logic clk_sys_in,
  input wire logic ack_in,
  input wire logic [7:0] rdata_in,
  output logic req_valid_out,
  output scs_pkg::scs_req_t req_out,
  output logic svc_fail_out
);
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
    svc_fail_out = 1'b0;
  end
  // one transfer: request up for one edge, answer sampled just after it
  task automatic xfer(input logic we, input logic [7:0] addr, input logic [7:0] wdata,
                      input logic fail, output logic ack, output logic [7:0] rdata);
    @(posedge clk_sys_in);
    req_valid_out <= 1'b1;
    req_out <= '{we: we, addr: addr, wdata: wdata};
    svc_fail_out <= fail;
    @(posedge clk_sys_in);
    req_valid_out <= 1'b0;
    req_out <= scs_pkg::scs_req_t'(~req_out); // released lines must not look valid
    svc_fail_out <= 1'b0;
    #1;
    ack = ack_in;
    rdata = rdata_in;
  endtask
  // two writes one edge apart: the second lands in the answer cycle of the first
  task automatic xfer_tight(input logic [7:0] addr, input logic [7:0] wdata, output logic ack2);
    @(posedge clk_sys_in);
    req_valid_out <= 1'b1;
    req_out <= '{we: 1'b1, addr: addr, wdata: wdata};
    @(posedge clk_sys_in);
    req_out <= '{we: 1'b1, addr: addr, wdata: ~wdata};
    @(posedge clk_sys_in);
    req_valid_out <= 1'b0;
    req_out <= scs_pkg::scs_req_t'(~req_out);
    #1;
    ack2 = ack_in;
  endtask
endmodule // scs_host

// ---- verification/scs_regs_tb.sv ----
// Purpose: self-checking bench of the sensor configuration and status slice
// Assumes: short measurement periods set by parameter
// Notes: all waits are bounded
`timescale 1ns/10ps
module scs_regs_tb;
  localparam int unsigned R0 = 5;
  localparam int unsigned R1 = 7;
  localparam int unsigned R2 = 11;
  logic clk_sys_in, resetn_in, video_neg_in, video_common_mode_in;
  logic req_valid, svc_fail, ack, tick, on_l, on_r, se, a;
  scs_pkg::scs_req_t req;
  logic [7:0] rdata, q;
  logic [1:0] rate;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] cfgs [6] = '{8'h0c, 8'h06, 8'h09, 8'h03, 8'h0f, 8'hf0};
  logic [1:0] ons [6] = '{2'b11, 2'b10, 2'b01, 2'b00, 2'b00, 2'b00};
  int unsigned gaps [4] = '{R0, R1, R2, R2};

  scs_regs #(.RATE0_CYC(R0), .RATE1_CYC(R1), .RATE2_CYC(R2)) DUT (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .req_valid_in(req_valid), .req_in(req),
    .svc_fail_in(svc_fail), .video_neg_in(video_neg_in), .video_common_mode_in(video_common_mode_in),
    .ack_out(ack), .rdata_out(rdata), .sensor_on_left_out(on_l), .sensor_on_right_out(on_r),
    .sample_rate_select_out(rate), .meas_tick_out(tick), .single_ended_out(se));
  scs_host HOST (.clk_sys_in(clk_sys_in), .ack_in(ack), .rdata_in(rdata),
    .req_valid_out(req_valid), .req_out(req), .svc_fail_out(svc_fail));

  // 100 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // strap levels are applied for the whole reset
  task automatic do_reset(input logic neg, input logic cm);
    @(posedge clk_sys_in);
    resetn_in <= 1'b0;
    video_neg_in <= neg;
    video_common_mode_in <= cm;
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] d, input logic fail);
    HOST.xfer(1'b1, addr, d, fail, a, q);
    chk({7'h00, a}, 8'h01, "write ack");
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    HOST.xfer(1'b0, addr, 8'h00, 1'b0, a, q);
    chk({7'h00, a}, 8'h01, "read ack");
    chk(q, exp, "read data");
  endtask

  // period between two consecutive ticks, in cycles
  task automatic tick_gap(input int unsigned exp);
    int n;
    int m;
    n = 0;
    while (tick !== 1'b1 && n < 200) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    m = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      m++;
    end while (tick !== 1'b1 && m < 200);
    // either wait running out is a mismatch and ends the run
    if (n >= 200 || tick !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t tick wait timed out", $time);
      give_verdict();
    end else begin
      chk(m[7:0], exp[7:0], "tick period");
    end
  endtask

  initial begin
    resetn_in = 1'b0;
    video_neg_in = 1'b1;
    video_common_mode_in = 1'b0;
    do_reset(1'b1, 1'b0);
    chk({7'h00, se}, 8'h00, "strap off");
    chk({6'h00, on_l, on_r}, 8'h00, "sensors at reset");
    rd(8'ha4, 8'h03);
    rd(8'hb0, 8'h00);
    rd(8'hff, 8'h5a);
    wr(8'hff, 8'h00, 1'b0);
    rd(8'hff, 8'h5a);
    // every enable and power-down pairing
    for (int i = 0; i < 6; i++) begin
      wr(8'ha4, cfgs[i], 1'b0);
      @(posedge clk_sys_in);
      #1;
      chk({6'h00, on_l, on_r}, {6'h00, ons[i]}, "sensor state");
      rd(8'ha4, cfgs[i] & 8'h3f);
    end
    // every rate code, both sensors on
    for (int r = 0; r < 4; r++) begin
      wr(8'ha4, {2'b00, r[1:0], 4'hc}, 1'b0);
      tick_gap(gaps[r]);
      chk({6'h00, rate}, r[7:0], "rate out");
    end
    // failed write is dropped and flagged, flag clears on read
    wr(8'ha4, 8'h03, 1'b1);
    rd(8'ha4, 8'h3c);
    rd(8'hb0, 8'h01);
    rd(8'hb0, 8'h00);
    // a request in the answer cycle gets no answer, is dropped and raises the flag
    HOST.xfer_tight(8'ha4, 8'h0c, a);
    chk({7'h00, a}, 8'h00, "refused ack");
    rd(8'ha4, 8'h0c);
    rd(8'hb0, 8'h01);
    do_reset(1'b0, 1'b0);
    chk({7'h00, se}, 8'h01, "strap on");
    rd(8'ha4, 8'h03);
    give_verdict();
  end
endmodule // scs_regs_tb
